// file: design/ugiae_consts.svh
// Offsets, field positions, reset values and timing counts of the USB
// global interrupt enable, function address and endpoint select bank.
// Assumes inclusion by bare name from the package and the bank module.
`ifndef UGIAE_CONSTS_SVH
`define UGIAE_CONSTS_SVH

// Register offsets in special-function-register space
`define UGIAE_OFS_IRQ_ENABLE 8'hbe
`define UGIAE_OFS_FUNC_ADDR 8'hc6
`define UGIAE_OFS_EP_SELECT 8'hc7

// Interrupt enable field positions
`define UGIAE_BIT_WAKE_CPU 5
`define UGIAE_BIT_END_OF_RESET 4
`define UGIAE_BIT_FRAME_START 3
`define UGIAE_BIT_SUSPEND 0

// Function address field positions
`define UGIAE_BIT_FILTER_ON 7
`define UGIAE_ADDR_MSB 6

// Endpoint select field
`define UGIAE_EP_MSB 3
`define UGIAE_EP_COUNT 7

// Writable bit masks; all other bits are reserved and read as zero
`define UGIAE_MASK_IRQ_ENABLE 8'h39
`define UGIAE_MASK_FUNC_ADDR 8'hff
`define UGIAE_MASK_EP_SELECT 8'h0f

// Reset values
`define UGIAE_RST_IRQ_ENABLE 8'h10
`define UGIAE_RST_FUNC_ADDR 8'h80
`define UGIAE_RST_EP_SELECT 8'h00

// Suspend detection: idle J state for three frame periods
`define UGIAE_CLK_HZ 100000000
`define UGIAE_SUSPEND_IDLE_MS 3
`define UGIAE_SUSPEND_IDLE_CYCLES (`UGIAE_SUSPEND_IDLE_MS * (`UGIAE_CLK_HZ / 1000))
`define UGIAE_IDLE_CNT_W 19

`endif

// file: design/ugiae_pkg.sv
// Types shared by the USB global register bank.
// Assumes ugiae_consts.svh is on the include path.
`include "ugiae_consts.svh"

package ugiae_pkg;

    // Whole state of the bank, registered as one word
    typedef struct packed {
        logic [7:0] irq_en;
        logic [7:0] func_addr;
        logic [7:0] ep_sel;
        logic [7:0] rdata;
        logic [`UGIAE_IDLE_CNT_W-1:0] idle_cnt;
        logic susp_sent;
    } ugiae_state_s;

endpackage : ugiae_pkg

// file: design/ugiae_regs.sv
// USB global interrupt enable, function address and endpoint select bank.
// Assumes an SFR port on the CPU clock; flags, bus reset and idle level come
// from logic on the same clock, so none of them is resynchronised here.
`include "ugiae_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ugiae_regs #(
    parameter logic [`UGIAE_IDLE_CNT_W-1:0] IDLE_CYCLES = `UGIAE_IDLE_CNT_W'(`UGIAE_SUSPEND_IDLE_CYCLES),
    parameter int EP_COUNT = `UGIAE_EP_COUNT
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic wake_cpu_flag,
    input wire logic end_of_bus_reset_flag,
    input wire logic frame_start_flag,
    input wire logic suspend_flag,
    input wire logic usb_bus_reset,
    input wire logic bus_idle_j,
    output logic suspend_detect,
    output logic usb_irq,
    output logic wake_cpu_irq_en,
    output logic end_of_bus_reset_irq_en,
    output logic frame_start_irq_en,
    output logic suspend_irq_en,
    output logic addr_filter_on,
    output logic [6:0] device_addr_field,
    output logic [3:0] endpoint_index,
    output logic [EP_COUNT-1:0] endpoint_onehot
);

    ////////////////////////////////////////////////////////////////////////
    // State and decode helpers

    ugiae_pkg::ugiae_state_s st_q;
    ugiae_pkg::ugiae_state_s st_d;
    logic wr_ien;
    logic wr_addr;
    logic wr_ep;

    // One-hot endpoint decode; out-of-range numbers select nothing
    function automatic logic [EP_COUNT-1:0] ep_decode(input logic [3:0] idx);
        logic [EP_COUNT-1:0] oh;
        oh = '0;
        for (int i = 0; i < EP_COUNT; i++) begin
            if (idx == 4'(i)) begin
                oh[i] = 1'b1;
            end
        end
        return oh;
    endfunction : ep_decode

    assign wr_ien = sfr_wr && (sfr_addr == `UGIAE_OFS_IRQ_ENABLE);
    assign wr_addr = sfr_wr && (sfr_addr == `UGIAE_OFS_FUNC_ADDR);
    assign wr_ep = sfr_wr && (sfr_addr == `UGIAE_OFS_EP_SELECT);

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    // Register writes, read capture and the suspend idle timer
    always_comb begin
        st_d = st_q;
        if (wr_ien) begin
            st_d.irq_en = sfr_wdata & `UGIAE_MASK_IRQ_ENABLE;
        end
        if (wr_addr) begin
            st_d.func_addr = sfr_wdata & `UGIAE_MASK_FUNC_ADDR;
        end
        // Bus reset wins over a firmware write in the same cycle for the address field; the filter bit takes the written value
        if (usb_bus_reset) begin
            st_d.func_addr[`UGIAE_ADDR_MSB:0] = 7'h00;
        end
        if (wr_ep) begin
            st_d.ep_sel = sfr_wdata & `UGIAE_MASK_EP_SELECT;
        end
        // Read data shows the value held before this cycle's write
        if (sfr_rd) begin
            unique case (sfr_addr)
                `UGIAE_OFS_IRQ_ENABLE: st_d.rdata = st_q.irq_en;
                `UGIAE_OFS_FUNC_ADDR: st_d.rdata = st_q.func_addr;
                `UGIAE_OFS_EP_SELECT: st_d.rdata = st_q.ep_sel;
                default: st_d.rdata = 8'h00;
            endcase
        end
        // Count idle cycles; pulse once, rearm when the bus leaves J or a bus reset arrives
        if (!bus_idle_j || usb_bus_reset) begin
            st_d.idle_cnt = '0;
            st_d.susp_sent = 1'b0;
        end else if (!st_q.susp_sent) begin
            if (st_q.idle_cnt == IDLE_CYCLES - `UGIAE_IDLE_CNT_W'(1)) begin
                st_d.susp_sent = 1'b1;
            end else begin
                st_d.idle_cnt = st_q.idle_cnt + `UGIAE_IDLE_CNT_W'(1);
            end
        end
    end

    // Single state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q.irq_en <= `UGIAE_RST_IRQ_ENABLE;
            st_q.func_addr <= `UGIAE_RST_FUNC_ADDR;
            st_q.ep_sel <= `UGIAE_RST_EP_SELECT;
            st_q.rdata <= 8'h00;
            st_q.idle_cnt <= '0;
            st_q.susp_sent <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Suspend pulse lasts the one cycle in which the timer saturates; the
    // sent mark rises at the next edge, so a long idle gives one pulse only
    assign suspend_detect = bus_idle_j && !st_q.susp_sent
                            && (st_q.idle_cnt == IDLE_CYCLES - `UGIAE_IDLE_CNT_W'(1));
    assign sfr_rdata = st_q.rdata;
    assign wake_cpu_irq_en = st_q.irq_en[`UGIAE_BIT_WAKE_CPU];
    assign end_of_bus_reset_irq_en = st_q.irq_en[`UGIAE_BIT_END_OF_RESET];
    assign frame_start_irq_en = st_q.irq_en[`UGIAE_BIT_FRAME_START];
    assign suspend_irq_en = st_q.irq_en[`UGIAE_BIT_SUSPEND];
    assign addr_filter_on = st_q.func_addr[`UGIAE_BIT_FILTER_ON];
    assign device_addr_field = st_q.func_addr[`UGIAE_ADDR_MSB:0];
    assign endpoint_index = st_q.ep_sel[`UGIAE_EP_MSB:0];
    // Steers the per-endpoint port, byte counts and control to one endpoint
    assign endpoint_onehot = ep_decode(endpoint_index);

    // Combinational so a flag is gated the cycle it appears
    assign usb_irq = (wake_cpu_flag && wake_cpu_irq_en) || (end_of_bus_reset_flag && end_of_bus_reset_irq_en)
                     || (frame_start_flag && frame_start_irq_en) || (suspend_flag && suspend_irq_en);

    ////////////////////////////////////////////////////////////////////////
    // Checks

    property p_reserved_zero;
        @(posedge clock) disable iff (!rst_n)
        ((st_q.irq_en & ~`UGIAE_MASK_IRQ_ENABLE) == 8'h00) && (st_q.ep_sel[7:4] == 4'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_wake_en;
        @(posedge clock) disable iff (!rst_n)
        wr_ien |=> wake_cpu_irq_en == $past(sfr_wdata[5]);
    endproperty
    a_wake_en: assert property (p_wake_en) else $error("wake enable not written");

    property p_eor_en;
        @(posedge clock) disable iff (!rst_n)
        wr_ien |=> end_of_bus_reset_irq_en == $past(sfr_wdata[4]);
    endproperty
    a_eor_en: assert property (p_eor_en) else $error("end of reset enable not written");

    property p_sof_en;
        @(posedge clock) disable iff (!rst_n)
        wr_ien ##1 !wr_ien |=> frame_start_irq_en == $past(sfr_wdata[3], 2);
    endproperty
    a_sof_en: assert property (p_sof_en) else $error("frame start enable lost");

    property p_susp_en;
        @(posedge clock) disable iff (!rst_n)
        wr_ien |=> suspend_irq_en == $past(sfr_wdata[0]);
    endproperty
    a_susp_en: assert property (p_susp_en) else $error("suspend enable not written");

    property p_filter;
        @(posedge clock) disable iff (!rst_n)
        wr_addr |=> addr_filter_on == $past(sfr_wdata[7]);
    endproperty
    a_filter: assert property (p_filter) else $error("filter bit not written");

    property p_bus_reset_addr;
        @(posedge clock) disable iff (!rst_n)
        usb_bus_reset |=> device_addr_field == 7'h00 && $stable(addr_filter_on) || $past(wr_addr);
    endproperty
    a_bus_reset_addr: assert property (p_bus_reset_addr) else $error("address not cleared");

    property p_ep_sel;
        @(posedge clock) disable iff (!rst_n)
        wr_ep |=> endpoint_index == $past(sfr_wdata[3:0]) && (endpoint_onehot == ep_decode($past(sfr_wdata[3:0])));
    endproperty
    a_ep_sel: assert property (p_ep_sel) else $error("endpoint select wrong");

    property p_irq_gate;
        @(posedge clock) disable iff (!rst_n)
        (usb_irq == 1'b0) |-> !(suspend_flag && suspend_irq_en) && !(frame_start_flag && frame_start_irq_en);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("enabled flag did not interrupt");

    property p_suspend_idle;
        @(posedge clock) disable iff (!rst_n)
        suspend_detect |-> bus_idle_j && $past(bus_idle_j) ##1 !suspend_detect;
    endproperty
    a_suspend_idle: assert property (p_suspend_idle) else $error("suspend without idle");

endmodule : ugiae_regs

`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the USB enable, address and endpoint select bank.
// Assumes the bank module and its constants header are compiled first.
`include "ugiae_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam int IDLE = 16;
    integer seed = 32'h2ded3d67;
    int checks = 0, mismatches = 0, pulses = 0;
    int m_ien = 8'h10, m_fa = 8'h80, m_es = 8'h00, m_rd = 0;
    logic clock = 1'b0, rst_n = 1'b0;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, usb_bus_reset = 1'b0, bus_idle_j = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic [3:0] flags = 4'h0;
    logic suspend_detect, usb_irq, wake_en, eor_en, sof_en, susp_en, filt;
    logic [6:0] dev_addr, onehot;
    logic [3:0] ep_idx;
    logic [7:0] amap [4] = '{8'hbe, 8'hc6, 8'hc7, 8'h55};

    ugiae_regs #(.IDLE_CYCLES(`UGIAE_IDLE_CNT_W'(IDLE)), .EP_COUNT(7)) u_dut (
        .clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .wake_cpu_flag(flags[3]),
        .end_of_bus_reset_flag(flags[2]), .frame_start_flag(flags[1]), .suspend_flag(flags[0]),
        .usb_bus_reset(usb_bus_reset), .bus_idle_j(bus_idle_j), .suspend_detect(suspend_detect),
        .usb_irq(usb_irq), .wake_cpu_irq_en(wake_en), .end_of_bus_reset_irq_en(eor_en),
        .frame_start_irq_en(sof_en), .suspend_irq_en(susp_en), .addr_filter_on(filt),
        .device_addr_field(dev_addr), .endpoint_index(ep_idx), .endpoint_onehot(onehot));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, random flag levels, watchdog
    initial begin
        forever #5 clock = ~clock;
    end

    always @(posedge clock) flags <= 4'($random(seed));

    // Whole run is a few hundred cycles, so this only trips on a hang
    initial begin
        #50us;
        mismatches++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checking helpers
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // Outputs settle by the falling edge, so the model is compared there, reset included
    always @(negedge clock) begin
        chk("irq_enable", {2'b00, wake_en, eor_en, sof_en, 2'b00, susp_en}, 8'(m_ien));
        chk("address", {filt, dev_addr}, 8'(m_fa));
        chk("endpoint", {4'h0, ep_idx}, 8'(m_es));
        chk("onehot", {1'b0, onehot}, (m_es < 7) ? 8'(1 << m_es) : 8'h00);
        chk("read_data", sfr_rdata, 8'(m_rd));
        chk("irq", {7'h00, usb_irq}, {7'h00, |(flags & {m_ien[5], m_ien[4], m_ien[3], m_ien[0]})});
        if (suspend_detect === 1'b1) pulses++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus tasks; each starts and ends just after a rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic br);
        sfr_addr <= a;
        sfr_wdata <= v;
        sfr_wr <= 1'b1;
        usb_bus_reset <= br;
        @(posedge clock);
        sfr_wr <= 1'b0;
        usb_bus_reset <= 1'b0;
        if (a == 8'hbe) m_ien = v & 8'h39;
        if (a == 8'hc6) m_fa = v;
        if (a == 8'hc7) m_es = v & 8'h0f;
        if (br) m_fa = m_fa & 8'h80;
        // One idle edge so a following call never re-raises a strobe in this step
        @(posedge clock);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clock);
        sfr_rd <= 1'b0;
        m_rd = (a == 8'hbe) ? m_ien : (a == 8'hc6) ? m_fa : (a == 8'hc7) ? m_es : 0;
        @(posedge clock);
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        // Each enable bit alone; firmware never sets reserved bits
        for (int k = 0; k < 8; k++) begin
            wr(8'hbe, 8'(1 << k) & 8'h39, 1'b0);
            rd(8'hbe);
        end
        // Every endpoint code firmware may load
        for (int e = 0; e < 7; e++) begin
            wr(8'hc7, 8'(e), 1'b0);
            rd(8'hc7);
        end
        // Random traffic over the bank and one unmapped place, legal values only
        for (int i = 0; i < 60; i++) begin
            logic [7:0] a;
            logic [7:0] v;
            a = amap[2'($random(seed))];
            v = 8'($random(seed));
            if (a == 8'hbe) v = v & 8'h39;
            if (a == 8'hc7) v = 8'(v % 7);
            wr(a, v, 1'b0);
            rd(amap[2'($random(seed))]);
        end
        // Bus reset alone, then racing a firmware address write
        wr(8'hc6, 8'hff, 1'b0);
        wr(8'h55, 8'h00, 1'b1);
        rd(8'hc6);
        wr(8'hc6, 8'h7f, 1'b0);
        wr(8'hc6, 8'hbf, 1'b1);
        rd(8'hc6);
        // Idle just short of the limit, then long enough for one pulse
        bus_idle_j <= 1'b1;
        repeat (IDLE - 2) @(posedge clock);
        bus_idle_j <= 1'b0;
        @(posedge clock);
        chk("early_pulses", 8'(pulses), 8'h00);
        bus_idle_j <= 1'b1;
        repeat (3 * IDLE) @(posedge clock);
        chk("pulses", 8'(pulses), 8'h01);
        bus_idle_j <= 1'b0;
        repeat (2) @(posedge clock);
        report_and_stop();
    end
endmodule : tb

`default_nettype wire
